// ---- sdcd_regs.vh ----
`ifndef SDCD_REGS_VH
`define SDCD_REGS_VH
// mode-set bank code that targets the extended settings
`define SDCD_EXT_BANK_SEL      2'b10
// extended settings field layout
`define SDCD_PARTIAL_LSB       0
`define SDCD_PARTIAL_MSB       2
`define SDCD_TEMP_LSB          3
`define SDCD_TEMP_MSB          4
`define SDCD_OPMODE_LSB        5
`define SDCD_OPMODE_MSB        12
`define SDCD_EXT_WIDTH         13
`define SDCD_EXT_RESET         13'h0000
// partial refresh encodings
`define SDCD_PARTIAL_ALL       3'h0
`define SDCD_PARTIAL_TWO       3'h1
`define SDCD_PARTIAL_ONE       3'h2
`define SDCD_PARTIAL_HALF      3'h5
`define SDCD_PARTIAL_QUARTER   3'h6
// temperature refresh encodings
`define SDCD_TEMP_SENSOR       2'h0
`define SDCD_TEMP_45C          2'h1
`define SDCD_TEMP_15C          2'h2
`define SDCD_TEMP_85C          2'h3
// command codes reported on the decoded command output
`define SDCD_CMD_NOP           4'h0
`define SDCD_CMD_ACTIVATE      4'h1
`define SDCD_CMD_READ          4'h2
`define SDCD_CMD_WRITE         4'h3
`define SDCD_CMD_PRECHARGE     4'h4
`define SDCD_CMD_MODE_SET      4'h5
`define SDCD_CMD_BURST_STOP    4'h6
`define SDCD_CMD_AUTO_REFRESH  4'h7
`define SDCD_CMD_SELF_REF_IN   4'h8
`define SDCD_CMD_POWER_DOWN    4'h9
`define SDCD_CMD_SUSPEND       4'ha
`define SDCD_CMD_DEEP_PD_IN    4'hb
`define SDCD_CMD_EXIT          4'hc
`define SDCD_CMD_ILLEGAL       4'hf
// self refresh interval counts in clocks per temperature setting
`define SDCD_SR_INTERVAL_15C   16'h4000
`define SDCD_SR_INTERVAL_45C   16'h2000
`define SDCD_SR_INTERVAL_85C   16'h0800
`define SDCD_SR_INTERVAL_HOT   16'h0800
`define SDCD_SR_INTERVAL_COLD  16'h4000
`endif

// ---- sdcd_bank_mem.v ----
`timescale 1ns/1ps
// small per-bank open-row flag store, registered read port
module sdcd_bank_mem #(
  parameter BANKS = 4
) (
  ref_clk,
  rst_b,
  wrEn,
  wrAll,
  wrBank,
  wrVal,
  rdBank,
  rdVal,
  allFlags
);
  input  wire         ref_clk;   // clock
  input  wire         rst_b;     // async reset, active low
  input  wire         wrEn;      // write strobe
  input  wire         wrAll;     // write every bank
  input  wire [1:0]   wrBank;    // bank to write
  input  wire         wrVal;     // new open flag
  input  wire [1:0]   rdBank;    // bank to look up
  output reg          rdVal;     // registered open flag
  output wire [BANKS-1:0] allFlags; // all open flags

  reg [BANKS-1:0] open_q;        // open-row flags
  integer i;

  assign allFlags = open_q;

  // flag updates, all-bank write for precharge all
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      open_q <= {BANKS{1'b0}};
    end else begin
      for (i = 0; i < BANKS; i = i + 1) begin
        if (wrEn && (wrAll || (wrBank == i[1:0]))) begin
          open_q[i] <= wrVal;
        end
      end
    end
  end

  // registered read port
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdVal <= 1'b0;
    end else begin
      rdVal <= open_q[rdBank];
    end
  end
endmodule // sdcd_bank_mem

// ---- sdcd_cmd_decode.v ----
`timescale 1ns/1ps
// Notes on behaviour
// - decode strobes and mask at rising edge
// - qualify commands with current and previous enable
// - bank state comes from selected bank; mode set, refresh and deep power down need all banks idle
// - activate, read, write, precharge; bit ten variants
// - mode set, refresh, self refresh, burst stop, mask
// - power down entry and exits on enable
// - enable falling mid-burst gives clock suspend
// - deep power down entry from idle
// - bank code two loads extended settings
// - partial select keeps four, two, one banks
// - half or quarter of bank zero
// - temperature field resets to sensor mode
// - fixed periods for 45, 15, 85 degrees
// - sensor shortens interval hot, lengthens cold
// - settings held until reprogrammed
// - excluded banks get no self refresh
`include "sdcd_regs.vh"
module sdcd_cmd_decode #(
  parameter BURST_LEN = 4          // clocks a burst lasts
) (
  ref_clk,
  rst_b,
  clkEn,
  chipSel_b,
  rowStb_b,
  colStb_b,
  wrEn_b,
  dataMask,
  bankSel,
  addr,
  dieHot,
  cmdCode,
  cmdValid,
  extModeCfg,
  inSelfRefresh,
  inPowerDown,
  inClockSuspend,
  inDeepPowerDown,
  burstActive,
  dataEnable,
  autoPrecharge,
  refreshStrobe,
  refreshBank,
  refreshRowLimit,
  refreshAll
);
  input  wire        ref_clk;          // 25 MHz clock
  input  wire        rst_b;            // async reset, active low
  input  wire        clkEn;            // clock enable pin
  input  wire        chipSel_b;        // chip select, active low
  input  wire        rowStb_b;         // row strobe, active low
  input  wire        colStb_b;         // column strobe, active low
  input  wire        wrEn_b;           // write enable, active low
  input  wire        dataMask;         // data mask, high disables
  input  wire [1:0]  bankSel;          // bank select pins
  input  wire [12:0] addr;             // address pins
  input  wire        dieHot;           // temperature sensor: hot
  output reg  [3:0]  cmdCode;          // last decoded command
  output reg         cmdValid;         // pulse per decoded command, illegal included
  output reg  [12:0] extModeCfg;       // extended_mode_config contents
  output reg         inSelfRefresh;    // self refresh state
  output reg         inPowerDown;      // power down state
  output reg         inClockSuspend;   // clock suspend state
  output reg         inDeepPowerDown;  // deep power down state
  output reg         burstActive;      // burst in progress
  output reg         dataEnable;       // data path enabled
  output reg         autoPrecharge;    // last read/write had auto precharge
  output reg         refreshStrobe;    // one internal refresh pulse
  output reg  [1:0]  refreshBank;      // bank refreshed
  output reg  [1:0]  refreshRowLimit;  // 0 full, 1 half, 2 quarter
  output reg         refreshAll;       // refresh hits all banks

  // power states
  localparam ST_NORMAL  = 3'h0;
  localparam ST_SELF    = 3'h1;
  localparam ST_PDOWN   = 3'h2;
  localparam ST_SUSPEND = 3'h3;
  localparam ST_DEEP    = 3'h4;

  reg  [2:0]  state_q;                  // power state
  reg  [2:0]  state_d;
  reg         clkEnPrev_q;              // enable one clock earlier
  reg  [7:0]  burstCnt_q;               // remaining burst clocks
  reg  [7:0]  burstCnt_d;
  reg  [3:0]  cmd_d;                    // decoded command
  reg  [15:0] srTimer_q;                // self refresh interval timer
  reg  [1:0]  srBank_q;                 // self refresh bank pointer
  reg         bankWr;                   // open flag write
  reg         bankWrAll;
  reg         bankWrVal;
  wire [3:0]  openFlags;                // open flags of all banks
  wire        allIdle;
  wire        selOpen;

  // open flag store per bank
  // the registered lookup is left open: decode needs the flag in the same cycle
  sdcd_bank_mem #(
    .BANKS (4)
  ) u_banks (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .wrEn     (bankWr),
    .wrAll    (bankWrAll),
    .wrBank   (bankSel),
    .wrVal    (bankWrVal),
    .rdBank   (bankSel),
    .rdVal    (),
    .allFlags (openFlags)
  );

  assign allIdle = (openFlags == 4'h0);
  assign selOpen = openFlags[bankSel];

  // interval for the self refresh timer from settings and sensor
  function [15:0] srInterval;
    input [1:0] temp;
    input       hot;
    begin
      case (temp)
        `SDCD_TEMP_45C: srInterval = `SDCD_SR_INTERVAL_45C;
        `SDCD_TEMP_15C: srInterval = `SDCD_SR_INTERVAL_15C;
        `SDCD_TEMP_85C: srInterval = `SDCD_SR_INTERVAL_85C;
        default: srInterval = hot ? `SDCD_SR_INTERVAL_HOT : `SDCD_SR_INTERVAL_COLD;
      endcase
    end
  endfunction

  // highest bank kept by the partial refresh setting
  function [1:0] srTopBank;
    input [2:0] part;
    begin
      case (part)
        `SDCD_PARTIAL_ALL: srTopBank = 2'h3;
        `SDCD_PARTIAL_TWO: srTopBank = 2'h1;
        default:           srTopBank = 2'h0;
      endcase
    end
  endfunction

  // command decode from sampled strobes and both enable samples
  always @* begin
    cmd_d     = `SDCD_CMD_NOP;
    bankWr    = 1'b0;
    bankWrAll = 1'b0;
    bankWrVal = 1'b0;
    if (state_q == ST_NORMAL && clkEnPrev_q) begin
      if (!clkEn && burstCnt_q != 8'h00) begin
        cmd_d = `SDCD_CMD_SUSPEND;
      end else if (chipSel_b) begin
        cmd_d = clkEn ? `SDCD_CMD_NOP : `SDCD_CMD_POWER_DOWN;
      end else begin
        case ({rowStb_b, colStb_b, wrEn_b})
          3'b011: begin
            // a bank that already holds an open row cannot take another
            if (clkEn && !selOpen) begin
              cmd_d  = `SDCD_CMD_ACTIVATE;
              bankWr = 1'b1;
            end else begin
              cmd_d  = `SDCD_CMD_ILLEGAL;
            end
            bankWrVal = 1'b1;
          end
          3'b101: cmd_d = selOpen ? `SDCD_CMD_READ : `SDCD_CMD_ILLEGAL;
          3'b100: cmd_d = selOpen ? `SDCD_CMD_WRITE : `SDCD_CMD_ILLEGAL;
          3'b010: begin
            cmd_d     = `SDCD_CMD_PRECHARGE;
            bankWr    = 1'b1;
            bankWrAll = addr[10];
          end
          3'b000: cmd_d = allIdle ? `SDCD_CMD_MODE_SET : `SDCD_CMD_ILLEGAL;
          3'b001: cmd_d = !allIdle ? `SDCD_CMD_ILLEGAL :
                          (clkEn ? `SDCD_CMD_AUTO_REFRESH : `SDCD_CMD_SELF_REF_IN);
          3'b110: cmd_d = clkEn ? `SDCD_CMD_BURST_STOP :
                          (allIdle ? `SDCD_CMD_DEEP_PD_IN : `SDCD_CMD_ILLEGAL);
          3'b111: cmd_d = clkEn ? `SDCD_CMD_NOP : `SDCD_CMD_POWER_DOWN;
          default: cmd_d = `SDCD_CMD_NOP;
        endcase
      end
    end else if (state_q != ST_NORMAL && !clkEnPrev_q && clkEn) begin
      // exit from low power states only; an enable rise after an
      // ignored low-enable cycle in normal state decodes nothing
      if (state_q == ST_DEEP || state_q == ST_SUSPEND) begin
        // deep power down and clock suspend leave on any enable rise
        cmd_d = `SDCD_CMD_EXIT;
      end else if (chipSel_b || (rowStb_b && colStb_b)) begin
        // power down and self refresh need a deselect or row and column strobes both high
        cmd_d = `SDCD_CMD_EXIT;
      end
    end
  end

  // burst length tracking
  always @* begin
    burstCnt_d = burstCnt_q;
    if (cmd_d == `SDCD_CMD_READ || cmd_d == `SDCD_CMD_WRITE) begin
      burstCnt_d = BURST_LEN[7:0];
    end else if (cmd_d == `SDCD_CMD_BURST_STOP) begin
      burstCnt_d = 8'h00;
    end else if (burstCnt_q != 8'h00 && state_q != ST_SUSPEND && cmd_d != `SDCD_CMD_SUSPEND) begin
      burstCnt_d = burstCnt_q - 8'h01;
    end
  end

  // power state transitions
  always @* begin
    state_d = state_q;
    case (cmd_d)
      `SDCD_CMD_SELF_REF_IN: state_d = ST_SELF;
      `SDCD_CMD_POWER_DOWN:  state_d = ST_PDOWN;
      `SDCD_CMD_SUSPEND:     state_d = ST_SUSPEND;
      `SDCD_CMD_DEEP_PD_IN:  state_d = ST_DEEP;
      `SDCD_CMD_EXIT:        state_d = ST_NORMAL;
      default:               state_d = state_q;
    endcase
  end

  // command and state registers
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q         <= ST_NORMAL;
      clkEnPrev_q     <= 1'b1;
      burstCnt_q      <= 8'h00;
      cmdCode         <= `SDCD_CMD_NOP;
      cmdValid        <= 1'b0;
      inSelfRefresh   <= 1'b0;
      inPowerDown     <= 1'b0;
      inClockSuspend  <= 1'b0;
      inDeepPowerDown <= 1'b0;
      burstActive     <= 1'b0;
      dataEnable      <= 1'b0;
      autoPrecharge   <= 1'b0;
    end else begin
      clkEnPrev_q     <= clkEn;
      state_q         <= state_d;
      burstCnt_q      <= burstCnt_d;
      cmdCode         <= cmd_d;
      cmdValid        <= (cmd_d != `SDCD_CMD_NOP);
      inSelfRefresh   <= (state_d == ST_SELF);
      inPowerDown     <= (state_d == ST_PDOWN);
      inClockSuspend  <= (state_d == ST_SUSPEND);
      inDeepPowerDown <= (state_d == ST_DEEP);
      burstActive     <= (burstCnt_d != 8'h00);
      dataEnable      <= !dataMask;
      if (cmd_d == `SDCD_CMD_READ || cmd_d == `SDCD_CMD_WRITE) begin
        autoPrecharge <= addr[10];
      end
    end
  end

  // extended settings load; held until the next load
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      extModeCfg <= `SDCD_EXT_RESET;
    end else if (cmd_d == `SDCD_CMD_MODE_SET && bankSel == `SDCD_EXT_BANK_SEL) begin
      extModeCfg <= addr;
    end
  end

  // internal refresh: auto refresh all banks, self refresh per settings
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      srTimer_q       <= 16'h0000;
      srBank_q        <= 2'h0;
      refreshStrobe   <= 1'b0;
      refreshBank     <= 2'h0;
      refreshRowLimit <= 2'h0;
      refreshAll      <= 1'b0;
    end else begin
      refreshStrobe <= 1'b0;
      if (cmd_d == `SDCD_CMD_AUTO_REFRESH) begin
        refreshStrobe   <= 1'b1;
        refreshAll      <= 1'b1;
        refreshBank     <= 2'h0;
        refreshRowLimit <= 2'h0;
      end else if (state_q == ST_SELF) begin
        if (srTimer_q == 16'h0000) begin
          srTimer_q     <= srInterval(extModeCfg[`SDCD_TEMP_MSB:`SDCD_TEMP_LSB], dieHot);
          refreshStrobe <= 1'b1;
          refreshAll    <= 1'b0;
          refreshBank   <= srBank_q;
          case (extModeCfg[`SDCD_PARTIAL_MSB:`SDCD_PARTIAL_LSB])
            `SDCD_PARTIAL_HALF:    refreshRowLimit <= 2'h1;
            `SDCD_PARTIAL_QUARTER: refreshRowLimit <= 2'h2;
            default:               refreshRowLimit <= 2'h0;
          endcase
          if (srBank_q >= srTopBank(extModeCfg[`SDCD_PARTIAL_MSB:`SDCD_PARTIAL_LSB])) begin
            srBank_q <= 2'h0;
          end else begin
            srBank_q <= srBank_q + 2'h1;
          end
        end else begin
          srTimer_q <= srTimer_q - 16'h0001;
        end
      end else begin
        srTimer_q <= 16'h0000;
        srBank_q  <= 2'h0;
      end
    end
  end
endmodule // sdcd_cmd_decode

// ---- sdcd_cmd_decode_props.sv ----
`timescale 1ns/1ps
`include "sdcd_regs.vh"
// watches the decoder pins and ties several decoded results to the strobes that caused them
module sdcd_cmd_decode_props (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        clkEn,
  input wire logic        chipSel_b,
  input wire logic        rowStb_b,
  input wire logic        colStb_b,
  input wire logic        wrEn_b,
  input wire logic        dataMask,
  input wire logic [1:0]  bankSel,
  input wire logic [12:0] addr,
  input wire logic [3:0]  cmdCode,
  input wire logic        cmdValid,
  input wire logic [12:0] extModeCfg,
  input wire logic        inSelfRefresh,
  input wire logic        inPowerDown,
  input wire logic        inClockSuspend,
  input wire logic        inDeepPowerDown,
  input wire logic        burstActive,
  input wire logic        dataEnable,
  input wire logic        autoPrecharge,
  input wire logic        refreshStrobe,
  input wire logic [1:0]  refreshBank,
  input wire logic [1:0]  refreshRowLimit
);
  wire [3:0] strb = {chipSel_b, rowStb_b, colStb_b, wrEn_b}; // strobes as one command word
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_ext_load; cmdValid && cmdCode == `SDCD_CMD_MODE_SET && $past(bankSel) == 2'b10 |-> extModeCfg == $past(addr); endproperty
  a_ext_load: assert property (p_ext_load) else $error("extended settings not loaded from address");
  property p_ext_hold; $changed(extModeCfg) |-> cmdValid && cmdCode == `SDCD_CMD_MODE_SET; endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("extended settings changed without mode set");
  property p_desel; $past(rst_b) && $past(chipSel_b) && $past(clkEn) && $past(clkEn, 2) |-> !cmdValid; endproperty
  a_desel: assert property (p_desel) else $error("deselect produced a command");
  property p_act; $past(rst_b) && $past(strb) == 4'h3 && $past(clkEn) && $past(clkEn, 2) |-> cmdValid && cmdCode inside {`SDCD_CMD_ACTIVATE, `SDCD_CMD_ILLEGAL}; endproperty
  a_act: assert property (p_act) else $error("activate strobes decoded wrongly");
  property p_rd_ap; cmdValid && cmdCode inside {`SDCD_CMD_READ, `SDCD_CMD_WRITE} |-> autoPrecharge == $past(addr[10]); endproperty
  a_rd_ap: assert property (p_rd_ap) else $error("auto precharge flag differs from address bit ten");
  property p_mask; $past(rst_b) |-> dataEnable == !$past(dataMask); endproperty
  a_mask: assert property (p_mask) else $error("data enable does not follow mask");
  property p_pd_in; $past(rst_b) && $past(chipSel_b) && !$past(clkEn) && $past(clkEn, 2) && !$past(burstActive) |-> inPowerDown; endproperty
  a_pd_in: assert property (p_pd_in) else $error("power down not entered");
  property p_susp; $past(rst_b) && $past(burstActive) && !$past(clkEn) && $past(clkEn, 2) |-> inClockSuspend && !inPowerDown; endproperty
  a_susp: assert property (p_susp) else $error("enable fall in burst did not suspend");
  property p_deep; $past(rst_b) && $past(strb) == 4'h6 && !$past(clkEn) && $past(clkEn, 2) && !$past(burstActive) |-> inDeepPowerDown || cmdCode == `SDCD_CMD_ILLEGAL; endproperty
  a_deep: assert property (p_deep) else $error("deep power down not entered");
  property p_sr_strobe; $rose(inSelfRefresh) |-> ##[0:3] refreshStrobe; endproperty
  a_sr_strobe: assert property (p_sr_strobe) else $error("no refresh after self refresh entry");
  property p_half; refreshStrobe && inSelfRefresh && extModeCfg[2:0] == `SDCD_PARTIAL_HALF |-> refreshBank == 2'b00 && refreshRowLimit == 2'b01; endproperty
  a_half: assert property (p_half) else $error("half bank refresh hit wrong rows");
endmodule // sdcd_cmd_decode_props

bind sdcd_cmd_decode sdcd_cmd_decode_props u_props (
  .ref_clk(ref_clk), .rst_b(rst_b), .clkEn(clkEn), .chipSel_b(chipSel_b), .rowStb_b(rowStb_b),
  .colStb_b(colStb_b), .wrEn_b(wrEn_b), .dataMask(dataMask), .bankSel(bankSel), .addr(addr),
  .cmdCode(cmdCode), .cmdValid(cmdValid), .extModeCfg(extModeCfg), .inSelfRefresh(inSelfRefresh),
  .inPowerDown(inPowerDown), .inClockSuspend(inClockSuspend), .inDeepPowerDown(inDeepPowerDown),
  .burstActive(burstActive), .dataEnable(dataEnable), .autoPrecharge(autoPrecharge),
  .refreshStrobe(refreshStrobe), .refreshBank(refreshBank), .refreshRowLimit(refreshRowLimit)
);

// ---- sdcd_ctrl_model.sv ----
`timescale 1ns/1ps
// memory controller stand-in: drives the command pins just after each rising edge
module sdcd_ctrl_model (
  input  wire logic        ref_clk,
  output logic             clkEn,
  output logic             chipSel_b,
  output logic             rowStb_b,
  output logic             colStb_b,
  output logic             wrEn_b,
  output logic             dataMask,
  output logic [1:0]       bankSel,
  output logic [12:0]      addr
);
  // idle pins at time zero: deselected, enable high
  initial begin
    clkEn = 1'b1;
    {chipSel_b, rowStb_b, colStb_b, wrEn_b} = 4'hf;
    dataMask = 1'b0;
    bankSel = 2'b00;
    addr = 13'h0000;
  end
  // present one command, held until the next rising edge has sampled it
  task send(input logic [3:0] s, input logic ce, input logic [1:0] ba, input logic [12:0] a, input logic m);
    @(posedge ref_clk);
    #1;
    {chipSel_b, rowStb_b, colStb_b, wrEn_b} = s;
    clkEn = ce;
    bankSel = ba;
    dataMask = m;
    // extended settings go out with operating mode zero and legal codes only
    if (s == 4'h0 && ba == 2'b10) addr = {8'h00, a[4:3], (a[2:0] inside {3'h3, 3'h4, 3'h7}) ? 3'h0 : a[2:0]};
    else addr = a;
  endtask
  // full bring-up after deep power down; banks closed before settings load
  task reinit;
    send(4'h2, 1'b1, 2'b00, 13'h0400, 1'b0);
    send(4'h1, 1'b1, 2'b00, 13'h0000, 1'b0);
    send(4'h1, 1'b1, 2'b00, 13'h0000, 1'b0);
    send(4'h0, 1'b1, 2'b00, 13'h0000, 1'b0);
    send(4'h0, 1'b1, 2'b10, 13'h0000, 1'b0);
    send(4'hf, 1'b1, 2'b00, 13'h1fff, 1'b1);
  endtask
endmodule // sdcd_ctrl_model

// ---- testbench.sv ----
`timescale 1ns/1ps
`include "sdcd_regs.vh"
// drives the decoder through its command set and checks decoded results
module testbench;
  logic        ref_clk = 1'b0;  // 25 MHz clock
  logic        rst_b   = 1'b0;  // async reset, active low
  logic        dieHot  = 1'b0;  // sensor hot level
  wire         clkEn, chipSel_b, rowStb_b, colStb_b, wrEn_b, dataMask;  // command pins
  wire [1:0]   bankSel, refreshBank, refreshRowLimit;                     // bank and refresh fields
  wire [12:0]  addr, extModeCfg;                                          // address and settings
  wire [3:0]   cmdCode;                                                   // decoded command
  wire         cmdValid, inSelfRefresh, inPowerDown, inClockSuspend, inDeepPowerDown;
  wire         burstActive, dataEnable, autoPrecharge, refreshStrobe, refreshAll;
  int          fails = 0;        // mismatches
  int          total_checks = 0; // comparisons made
  logic [2:0]  partTab [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6}; // legal partial codes
  logic [2:0]  p;                // partial code under test
  logic [1:0]  b;                // bank under test
  logic [12:0] cfg;              // expected settings
  logic        m;                // data mask sent
  int          waitCnt;          // edges waited for a refresh pulse

  always #20 ref_clk = ~ref_clk;

  sdcd_ctrl_model u_ctl (.ref_clk(ref_clk), .clkEn(clkEn), .chipSel_b(chipSel_b), .rowStb_b(rowStb_b),
    .colStb_b(colStb_b), .wrEn_b(wrEn_b), .dataMask(dataMask), .bankSel(bankSel), .addr(addr));
  sdcd_cmd_decode #(.BURST_LEN(4)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .clkEn(clkEn),
    .chipSel_b(chipSel_b), .rowStb_b(rowStb_b), .colStb_b(colStb_b), .wrEn_b(wrEn_b), .dataMask(dataMask),
    .bankSel(bankSel), .addr(addr), .dieHot(dieHot), .cmdCode(cmdCode), .cmdValid(cmdValid),
    .extModeCfg(extModeCfg), .inSelfRefresh(inSelfRefresh), .inPowerDown(inPowerDown),
    .inClockSuspend(inClockSuspend), .inDeepPowerDown(inDeepPowerDown), .burstActive(burstActive),
    .dataEnable(dataEnable), .autoPrecharge(autoPrecharge), .refreshStrobe(refreshStrobe),
    .refreshBank(refreshBank), .refreshRowLimit(refreshRowLimit), .refreshAll(refreshAll));

  // compare seen against expected, count and report
  task check(input string name, input logic [12:0] seen, input logic [12:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // counts, verdict and end of run
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // wait for a refresh pulse; running out of edges is a mismatch and ends the run
  task wait_strobe(input int lim, output int n);
    for (n = 0; n < lim && refreshStrobe !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    if (refreshStrobe !== 1'b1) begin
      fails++;
      final_report;
    end
  endtask
  // one command then a deselect; decoded code, pulse and mask echo are checked
  task cmd(input logic [3:0] s, input logic ce, input logic [1:0] ba, input logic [12:0] a, input logic [3:0] exp);
    m = 1'($urandom);
    u_ctl.send(s, ce, ba, a, m);
    u_ctl.send(4'hf, ce, ~ba, ~a, ~m);
    check("cmdCode", cmdCode, exp);
    check("cmdValid", cmdValid, exp != `SDCD_CMD_NOP);
    check("dataEnable", dataEnable, !m);
  endtask
  // row span reported for a partial code
  function logic [1:0] row_limit(input logic [2:0] part);
    return (part == `SDCD_PARTIAL_HALF) ? 2'h1 : (part == `SDCD_PARTIAL_QUARTER) ? 2'h2 : 2'h0;
  endfunction
  // whether a bank may be refreshed under a partial code
  function logic bank_kept(input logic [2:0] part, input logic [1:0] bank);
    return (part == `SDCD_PARTIAL_ALL) || (part == `SDCD_PARTIAL_TWO && !bank[1]) || bank == 2'b00;
  endfunction

  // main sequence
  initial begin
    void'($urandom(32'hae4a7e66));
    repeat (16) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    check("extModeCfg", extModeCfg, `SDCD_EXT_RESET);
    for (int i = 0; i < 12; i++) begin
      cfg = {8'h00, (i < 4) ? i[1:0] : 2'($urandom), partTab[(i < 5) ? i : $urandom_range(4)]};
      cmd(4'h0, 1'b1, 2'b10, cfg, `SDCD_CMD_MODE_SET);
      check("extModeCfg", extModeCfg, cfg);
    end
    cmd(4'h0, 1'b1, 2'b00, 13'($urandom), `SDCD_CMD_MODE_SET);
    check("extModeCfg", extModeCfg, cfg);
    foreach (partTab[i]) begin
      p = partTab[i];
      dieHot = 1'($urandom);
      cfg = {8'h00, 2'($urandom), p};
      cmd(4'h0, 1'b1, 2'b10, cfg, `SDCD_CMD_MODE_SET);
      cmd(4'h1, 1'b0, 2'b00, 13'h0000, `SDCD_CMD_SELF_REF_IN);
      check("inSelfRefresh", inSelfRefresh, 1'b1);
      wait_strobe(8, waitCnt);
      check("refreshAll", refreshAll, 1'b0);
      check("refreshBank", bank_kept(p, refreshBank), 1'b1);
      check("refreshRowLimit", refreshRowLimit, row_limit(p));
      cmd(4'hf, 1'b1, 2'b00, 13'h0000, `SDCD_CMD_EXIT);
      check("inSelfRefresh", inSelfRefresh, 1'b0);
    end
    // sensor mode while hot: pulse spacing and the second kept bank
    dieHot = 1'b1;
    cfg = {8'h00, `SDCD_TEMP_SENSOR, `SDCD_PARTIAL_TWO};
    cmd(4'h0, 1'b1, 2'b10, cfg, `SDCD_CMD_MODE_SET);
    cmd(4'h1, 1'b0, 2'b00, 13'h0000, `SDCD_CMD_SELF_REF_IN);
    wait_strobe(8, waitCnt);
    @(posedge ref_clk);
    #1;
    wait_strobe(20000, waitCnt);
    check("srSpacing", 13'(waitCnt), 13'(`SDCD_SR_INTERVAL_HOT));
    check("refreshBank", refreshBank, 2'h1);
    cmd(4'hf, 1'b1, 2'b00, 13'h0000, `SDCD_CMD_EXIT);
    cmd(4'h1, 1'b1, 2'b00, 13'h0000, `SDCD_CMD_AUTO_REFRESH);
    check("inSelfRefresh", inSelfRefresh, 1'b0);
    check("refreshStrobe", refreshStrobe, 1'b1);
    check("refreshAll", refreshAll, 1'b1);
    check("refreshBank", refreshBank, 2'h0);
    b = 2'($urandom);
    cmd(4'h3, 1'b1, b, 13'($urandom), `SDCD_CMD_ACTIVATE);
    cmd(4'h0, 1'b1, 2'b10, 13'h0000, `SDCD_CMD_ILLEGAL);
    check("extModeCfg", extModeCfg, cfg);
    cmd(4'h5, 1'b1, b, 13'h0000, `SDCD_CMD_READ);
    check("autoPrecharge", autoPrecharge, 1'b0);
    check("burstActive", burstActive, 1'b1);
    u_ctl.send(4'hf, 1'b0, b, 13'h0000, 1'b0);
    u_ctl.send(4'hf, 1'b0, ~b, 13'h1fff, 1'b1);
    check("inClockSuspend", inClockSuspend, 1'b1);
    check("inPowerDown", inPowerDown, 1'b0);
    u_ctl.send(4'hf, 1'b1, b, 13'h0000, 1'b0);
    cmd(4'h6, 1'b1, b, 13'h0000, `SDCD_CMD_BURST_STOP);
    cmd(4'h4, 1'b1, b, 13'h0400, `SDCD_CMD_WRITE);
    check("autoPrecharge", autoPrecharge, 1'b1);
    cmd(4'h5, 1'b1, b + 2'd1, 13'h0000, `SDCD_CMD_ILLEGAL);
    repeat (8) @(posedge ref_clk);
    cmd(4'h2, 1'b1, 2'b00, 13'h0400, `SDCD_CMD_PRECHARGE);
    cmd(4'h5, 1'b1, b, 13'h0000, `SDCD_CMD_ILLEGAL);
    cmd(4'h3, 1'b0, b, 13'h0000, `SDCD_CMD_ILLEGAL);
    u_ctl.send(4'hf, 1'b1, b, 13'h0000, 1'b0);
    u_ctl.send(4'hf, 1'b1, ~b, 13'h1fff, 1'b1);
    cmd(4'hf, 1'b0, 2'b00, 13'h0000, `SDCD_CMD_POWER_DOWN);
    check("inPowerDown", inPowerDown, 1'b1);
    cmd(4'h7, 1'b1, 2'b00, 13'h0000, `SDCD_CMD_EXIT);
    check("inPowerDown", inPowerDown, 1'b0);
    cmd(4'h6, 1'b0, 2'b00, 13'h0000, `SDCD_CMD_DEEP_PD_IN);
    check("inDeepPowerDown", inDeepPowerDown, 1'b1);
    cmd(4'hf, 1'b1, 2'b00, 13'h0000, `SDCD_CMD_EXIT);
    check("inDeepPowerDown", inDeepPowerDown, 1'b0);
    u_ctl.reinit;
    check("extModeCfg", extModeCfg, 13'h0000);
    final_report;
  end
endmodule // testbench
